// [rtl/nor_flash_host.sv]
// Host controller driving an asynchronous page-mode NOR flash over its pins
// Notes on behaviour
// - Reads drive chip select and output gate low, write strobe and reset high.
// - Writes drive write strobe and chip select low, output gate high.
// - Host raises protect pin voltage only during accelerated programming.
// - Host does not reissue a program or erase that a reset interrupted; the user must.
// - Host does not poll for completion; busy only reports ready_busy_n after synchronising.
module nor_flash_host (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              sys_rst,
    // User request port
    input  wire logic                              req_valid,
    input  wire logic                              req_write,
    input  wire logic [nor_host_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [nor_host_pkg::DATA_W-1:0]   req_wdata,
    input  wire logic                              req_flash_reset,
    input  wire logic                              req_accel,
    input  wire logic                              req_protect_n,
    output logic                                   req_ready,
    output logic                                   rsp_valid,
    output logic [nor_host_pkg::DATA_W-1:0]        rsp_rdata,
    output logic                                   busy,
    // Flash pins
    output logic [nor_host_pkg::ADDR_W-1:0]        flash_addr,
    output logic                                   chip_sel_n,
    output logic                                   out_gate_n,
    output logic                                   write_n,
    output logic                                   flash_reset_n,
    output logic                                   protect_accel_pin,
    output logic                                   accel_high_voltage,
    input  wire logic [nor_host_pkg::DATA_W-1:0]   data_lines_in,
    output logic [nor_host_pkg::DATA_W-1:0]        data_lines_out,
    output logic                                   data_lines_oe,
    input  wire logic                              ready_busy_n
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        nor_host_pkg::state_type                 state;
        logic [nor_host_pkg::CNT_W-1:0]          cnt;
        logic [nor_host_pkg::ADDR_W-1:0]         addr;
        logic [nor_host_pkg::DATA_W-1:0]         wdata;
        logic [nor_host_pkg::DATA_W-1:0]         rdata;
        logic                                    page_ok;
        logic                                    cs_n;
        logic                                    oe_n;
        logic                                    we_n;
        logic                                    rst_n;
        logic                                    dq_oe;
        logic                                    rsp;
        logic                                    rdy;
        logic                                    wp;
        logic                                    acc;
        logic [nor_host_pkg::DATA_W-1:0]         dq_s1;
        logic [nor_host_pkg::DATA_W-1:0]         dq_s2;
        logic                                    rb_s1;
        logic                                    rb_s2;
        logic                                    busy;
    } regs_type;

    regs_type cur_ff;
    regs_type nxt_ff;

    function automatic logic [nor_host_pkg::CNT_W-1:0] cyc(input int n);
        cyc = nor_host_pkg::CNT_W'(n - 1);
    endfunction

    function automatic logic same_page(
        input logic [nor_host_pkg::ADDR_W-1:0] a,
        input logic [nor_host_pkg::ADDR_W-1:0] b);
        same_page = a[nor_host_pkg::ADDR_W-1:nor_host_pkg::PAGE_LSB] ==
                    b[nor_host_pkg::ADDR_W-1:nor_host_pkg::PAGE_LSB];
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rsp = 1'b0;
        // Pins from the device pass two flops before use
        nxt_ff.dq_s1 = data_lines_in;
        nxt_ff.dq_s2 = cur_ff.dq_s1;
        nxt_ff.rb_s1 = ready_busy_n;
        nxt_ff.rb_s2 = cur_ff.rb_s1;
        nxt_ff.busy = ~cur_ff.rb_s2;
        case (cur_ff.state)
            nor_host_pkg::ST_RESET: begin
                // Whole pulse width held before release
                if (cur_ff.cnt == '0) begin
                    nxt_ff.rst_n = 1'b1;
                    nxt_ff.cnt = cyc(nor_host_pkg::RESET_RECOVER_CYC);
                    nxt_ff.state = nor_host_pkg::ST_RECOVER;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - 1'b1;
                end
            end
            nor_host_pkg::ST_RECOVER: begin
                // Requests are held off here until the device recovers from reset
                if (cur_ff.cnt == '0) begin
                    nxt_ff.rdy = 1'b1;
                    nxt_ff.state = nor_host_pkg::ST_IDLE;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - 1'b1;
                end
            end
            nor_host_pkg::ST_IDLE: begin
                // Accel voltage only while writing is requested
                nxt_ff.acc = 1'b0;
                nxt_ff.wp = req_protect_n;
                if (req_flash_reset) begin
                    nxt_ff.rdy = 1'b0;
                    nxt_ff.rst_n = 1'b0;
                    nxt_ff.cs_n = 1'b1;
                    nxt_ff.oe_n = 1'b1;
                    nxt_ff.page_ok = 1'b0;
                    nxt_ff.cnt = cyc(nor_host_pkg::RESET_PULSE_CYC);
                    nxt_ff.state = nor_host_pkg::ST_RESET;
                end else if (req_valid && req_write) begin
                    nxt_ff.rdy = 1'b0;
                    nxt_ff.addr = req_addr;
                    nxt_ff.wdata = req_wdata;
                    nxt_ff.acc = req_accel;
                    nxt_ff.cs_n = 1'b0;
                    nxt_ff.oe_n = 1'b1;
                    nxt_ff.we_n = 1'b0;
                    nxt_ff.dq_oe = 1'b1;
                    nxt_ff.page_ok = 1'b0;
                    nxt_ff.cnt = cyc(nor_host_pkg::WE_PULSE_CYC);
                    nxt_ff.state = nor_host_pkg::ST_WRITE_LOW;
                end else if (req_valid) begin
                    nxt_ff.rdy = 1'b0;
                    nxt_ff.addr = req_addr;
                    nxt_ff.cs_n = 1'b0;
                    nxt_ff.oe_n = 1'b0;
                    nxt_ff.we_n = 1'b1;
                    // Short wait only when still selected in same page
                    if (cur_ff.page_ok && !cur_ff.cs_n &&
                        same_page(req_addr, cur_ff.addr)) begin
                        nxt_ff.cnt = cyc(nor_host_pkg::PAGE_ACCESS_CYC
                                         + 2);
                    end else begin
                        nxt_ff.cnt = cyc(nor_host_pkg::RANDOM_ACCESS_CYC
                                         + 2);
                    end
                    nxt_ff.state = nor_host_pkg::ST_READ;
                end else begin
                    // Deselect to standby; page must be reopened later
                    nxt_ff.cs_n = 1'b1;
                    nxt_ff.oe_n = 1'b1;
                    nxt_ff.page_ok = 1'b0;
                end
            end
            nor_host_pkg::ST_READ: begin
                // Extra two cycles cover the input synchroniser
                if (cur_ff.cnt == '0) begin
                    nxt_ff.rdata = cur_ff.dq_s2;
                    nxt_ff.rsp = 1'b1;
                    nxt_ff.rdy = 1'b1;
                    nxt_ff.page_ok = 1'b1;
                    nxt_ff.state = nor_host_pkg::ST_IDLE;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - 1'b1;
                end
            end
            nor_host_pkg::ST_WRITE_LOW: begin
                if (cur_ff.cnt == '0) begin
                    nxt_ff.we_n = 1'b1;
                    nxt_ff.cnt = cyc(nor_host_pkg::WE_HIGH_CYC);
                    nxt_ff.state = nor_host_pkg::ST_WRITE_HIGH;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - 1'b1;
                end
            end
            nor_host_pkg::ST_WRITE_HIGH: begin
                if (cur_ff.cnt == '0) begin
                    // Voltage drops with the strobes, never lingers idle
                    nxt_ff.acc = 1'b0;
                    nxt_ff.dq_oe = 1'b0;
                    nxt_ff.cs_n = 1'b1;
                    nxt_ff.rdy = 1'b1;
                    nxt_ff.rsp = 1'b1;
                    nxt_ff.state = nor_host_pkg::ST_IDLE;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - 1'b1;
                end
            end
            default: begin
                nxt_ff.state = nor_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff <= '{state: nor_host_pkg::ST_RESET,
                        cnt: cyc(nor_host_pkg::RESET_PULSE_CYC),
                        addr: nor_host_pkg::ADDR_RST,
                        wdata: nor_host_pkg::DATA_RST,
                        rdata: nor_host_pkg::DATA_RST,
                        dq_s1: nor_host_pkg::DATA_RST,
                        dq_s2: nor_host_pkg::DATA_RST,
                        cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        rb_s1: 1'b1, rb_s2: 1'b1, wp: 1'b1,
                        default: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign req_ready          = cur_ff.rdy;
    assign rsp_valid          = cur_ff.rsp;
    assign rsp_rdata          = cur_ff.rdata;
    assign busy               = cur_ff.busy;
    assign flash_addr         = cur_ff.addr;
    assign chip_sel_n         = cur_ff.cs_n;
    assign out_gate_n         = cur_ff.oe_n;
    assign write_n            = cur_ff.we_n;
    assign flash_reset_n      = cur_ff.rst_n;
    assign protect_accel_pin  = cur_ff.wp;
    assign accel_high_voltage = cur_ff.acc;
    assign data_lines_out     = cur_ff.wdata;
    assign data_lines_oe      = cur_ff.dq_oe;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence reset_low_s;
        !flash_reset_n [*8];
    endsequence

    read_levels_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !out_gate_n |-> !chip_sel_n && write_n && flash_reset_n && !data_lines_oe)
        else $error("read strobes wrong");
    write_levels_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !write_n |-> !chip_sel_n && out_gate_n && data_lines_oe)
        else $error("write strobes wrong");
    accel_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        accel_high_voltage |-> cur_ff.state inside {nor_host_pkg::ST_WRITE_LOW,
                                    nor_host_pkg::ST_WRITE_HIGH})
        else $error("accel voltage outside write");
    reset_width_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(flash_reset_n) |-> reset_low_s)
        else $error("reset pulse too short");
    idle_standby_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cur_ff.state == nor_host_pkg::ST_IDLE && !req_valid
         && !req_flash_reset) |=> chip_sel_n)
        else $error("no standby when idle");
    full_access_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($rose(!out_gate_n) && $past(chip_sel_n)) |-> !rsp_valid [*8])
        else $error("read too fast after standby");
    we_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(write_n) |-> !write_n [*5])
        else $error("write pulse too short");
    busy_sync_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !ready_busy_n [*4] |-> busy)
        else $error("busy not reported");

endmodule

// [rtl/nor_host_pkg.sv]
// Package: timing constants, widths and states for the NOR flash host
package nor_host_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 8;

    // Device timing figures in nanoseconds
    localparam int RANDOM_ACCESS_NS = 110;
    localparam int PAGE_ACCESS_NS   = 30;
    localparam int WE_PULSE_NS      = 35;
    localparam int WE_HIGH_NS       = 20;
    localparam int RESET_PULSE_NS   = 500;
    localparam int RESET_RECOVER_NS = 50;

    // Least times round up to whole cycles
    localparam int RANDOM_ACCESS_CYC =
        (RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ACCESS_CYC =
        (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_CYC =
        (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC =
        (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVER_CYC =
        (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 7;
    localparam int PAGE_LSB = 3;

    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RECOVER,
        ST_IDLE,
        ST_READ,
        ST_WRITE_LOW,
        ST_WRITE_HIGH
    } state_type;

endpackage

// [tb/nor_dev_model.sv]
// Behavioural page-mode NOR flash device facing the host controller
module nor_dev_model #(
    parameter logic [7:0] ID_CODE = 8'h3C // Arbitrary value
) (
    // Bus pins
    input  wire logic [23:0] flash_addr,
    input  wire logic        chip_sel_n,
    input  wire logic        out_gate_n,
    input  wire logic        write_n,
    input  wire logic        flash_reset_n,
    input  wire logic        accel_high_voltage,
    input  wire logic        protect_accel_pin,
    input  wire logic [15:0] wr_data,
    input  wire logic        wr_oe,
    output logic      [15:0] rd_data,
    output logic             ready_busy_n,
    // Rule breaks seen by the device
    output logic             viol
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [64];
    logic [15:0] last_q = 16'h0000;
    logic [23:0] last_a = 24'h000000;
    logic        cs_prev = 1'b1;
    logic        id_mode = 1'b0;
    logic [5:0]  wr_a = 6'h00;
    int          buf_n = -1;
    logic        on;
    time         t_chg = 0;
    time         t_we = 0;
    time         t_rst = 0;
    int          need = 110;
    initial begin
        viol = 1'b0;
        ready_busy_n = 1'b1;
        rd_data = 16'h0000;
        for (int i = 0; i < 64; i++) mem[i] = 16'(i) ^ 16'hA5C3;
    end
    // Page hit only while selected throughout and A23..A3 unchanged
    always @(flash_addr or chip_sel_n) begin
        if (flash_addr != last_a || chip_sel_n != cs_prev) begin
            need = (!chip_sel_n && !cs_prev &&
                    flash_addr[23:3] == last_a[23:3]) ? 30 : 110;
            t_chg = $time;
            last_a = flash_addr;
            cs_prev = chip_sel_n;
        end
    end
    // Polled off the clock edges; stale data shows inverted, not held
    initial begin
        #0.5;
        forever begin
            #1;
            on = !chip_sel_n && !out_gate_n && flash_reset_n;
            if (on && $time - t_chg >= need) begin
                last_q = id_mode ? {8'h00, ID_CODE} : mem[flash_addr[5:0]];
                rd_data = last_q;
            end else begin
                rd_data = ~last_q;
            end
            if ((wr_oe && on) || (accel_high_voltage && chip_sel_n))
                viol = 1'b1;
        end
    end
    always @(negedge write_n) t_we = $time;
    always @(posedge write_n) begin
        if (!chip_sel_n && flash_reset_n) begin
            if ($time - t_we < 35) viol = 1'b1;
            if (wr_data == 16'h0090) id_mode = 1'b1;
            else if (wr_data == 16'h00F0) id_mode = 1'b0;
            else if (wr_data == 16'h0025) buf_n = 0;
            else if (wr_data == 16'h0029) buf_n = -1;
            else if (wr_data == 16'h0030) begin
                for (int i = 0; i < 8; i++)
                    mem[{flash_addr[5:3], 3'(i)}] = 16'hFFFF;
            end else if (protect_accel_pin !== 1'b0 || accel_high_voltage ||
                         flash_addr[5:3] != 3'h0) begin
                // Open pin floats high, so only a driven low protects
                if (buf_n >= 0) buf_n++;
                if (buf_n > 16) viol = 1'b1;
                wr_a = flash_addr[5:0];
                mem[flash_addr[5:0]] = wr_data;
                fork
                    begin
                        ready_busy_n = 1'b0;
                        #200;
                        ready_busy_n = 1'b1;
                    end
                join_none
            end
        end
    end
    always @(negedge flash_reset_n) begin
        t_rst = $time;
        // A program cut short leaves its word unreliable
        if (ready_busy_n === 1'b0) mem[wr_a] = 16'hFFFF;
        ready_busy_n = 1'b1;
    end
    always @(posedge flash_reset_n) begin
        if ($time - t_rst < 500) viol = 1'b1;
        id_mode = 1'b0;
    end
endmodule

// [tb/nor_flash_host_tb.sv]
// Self-checking bench for the NOR flash host controller
module nor_flash_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
        $display("FAIL %0t got %h want %h", $time, a, b); end end
    localparam logic [7:0] ID = 8'h3C; // Arbitrary value
    logic mclk, sys_rst, req_valid, req_write, req_flash_reset, req_accel;
    logic req_protect_n, req_ready, rsp_valid, busy, chip_sel_n, out_gate_n;
    logic write_n, flash_reset_n, protect_accel_pin, accel_high_voltage;
    logic data_lines_oe, ready_busy_n, viol;
    logic [23:0] req_addr, flash_addr;
    logic [15:0] req_wdata, rsp_rdata, data_lines_out, dq_dev, q, d;
    logic [15:0] expv [64];
    logic [5:0]  a;
    int          error_cnt = 0, checks = 0, cycles = 0, n;
    nor_flash_host nor_flash_host_i (.mclk(mclk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_flash_reset(req_flash_reset),
        .req_accel(req_accel), .req_protect_n(req_protect_n),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .busy(busy), .flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
        .out_gate_n(out_gate_n), .write_n(write_n),
        .flash_reset_n(flash_reset_n), .protect_accel_pin(protect_accel_pin),
        .accel_high_voltage(accel_high_voltage),
        .data_lines_in(data_lines_oe ? data_lines_out : dq_dev),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
        .ready_busy_n(ready_busy_n));
    nor_dev_model #(.ID_CODE(ID)) nor_dev_model_i (.flash_addr(flash_addr),
        .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_n(write_n),
        .flash_reset_n(flash_reset_n), .accel_high_voltage(accel_high_voltage),
        .protect_accel_pin(protect_accel_pin),
        .wr_data(data_lines_out), .wr_oe(data_lines_oe), .rd_data(dq_dev),
        .ready_busy_n(ready_busy_n), .viol(viol));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Hang guard: the full sequence needs well under 2000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Entered at a falling edge; n counts cycles from take to response
    task automatic op(input logic w, input logic [23:0] ad,
                      input logic [15:0] dd);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(negedge mclk);
            k++;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = ad;
        req_wdata = dd;
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        q = rsp_rdata;
    endtask
    initial begin
        {sys_rst, req_protect_n} = 2'b11;
        {req_valid, req_write, req_flash_reset, req_accel} = 4'h0;
        req_addr = 24'h000000;
        req_wdata = 16'h0000;
        void'($urandom(32'h4901));
        for (int i = 0; i < 64; i++) expv[i] = 16'(i) ^ 16'hA5C3;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        op(1'b0, 24'h000010, 16'h0000);
        `CHK(n, 16)
        `CHK(q, expv[16])
        op(1'b0, 24'h000013, 16'h0000);
        `CHK(n, 6)
        `CHK(q, expv[19])
        op(1'b0, 24'h000018, 16'h0000);
        `CHK(n, 16)
        @(negedge mclk);
        op(1'b0, 24'h00001A, 16'h0000);
        `CHK(n, 16)
        op(1'b1, 24'h000000, 16'h0090);
        `CHK(n, 8)
        op(1'b0, 24'h000005, 16'h0000);
        `CHK(q, {8'h00, ID})
        op(1'b1, 24'h000000, 16'h00F0);
        op(1'b0, 24'h000005, 16'h0000);
        `CHK(q, expv[5])
        repeat (20) begin
            a = 6'($urandom);
            d = 16'($urandom) | 16'h8000;
            req_accel = 1'($urandom);
            op(1'b1, {18'h00000, a}, d);
            `CHK(n, 8)
            req_accel = 1'b0;
            expv[a] = d;
            op(1'b0, {18'h00000, a}, 16'h0000);
            `CHK(q, expv[a])
        end
        op(1'b1, 24'h000000, 16'h0025);
        for (int i = 48; i < 64; i++) begin
            d = 16'($urandom) | 16'h8000;
            op(1'b1, 24'(i), d);
            expv[i] = d;
        end
        op(1'b1, 24'h000000, 16'h0029);
        op(1'b0, 24'h00003B, 16'h0000);
        `CHK(q, expv[59])
        op(1'b1, 24'h000028, 16'h0030);
        for (int i = 40; i < 48; i++) expv[i] = 16'hFFFF;
        op(1'b0, 24'h00002D, 16'h0000);
        `CHK(q, expv[45])
        repeat (40) @(negedge mclk);
        `CHK(busy, 1'b0)
        op(1'b1, 24'h000021, 16'h9876);
        expv[33] = 16'h9876;
        repeat (2) @(negedge mclk);
        `CHK(busy, 1'b1)
        op(1'b1, 24'h000000, 16'h0090);
        req_flash_reset = 1'b1;
        @(negedge mclk);
        req_flash_reset = 1'b0;
        `CHK(flash_reset_n, 1'b0)
        `CHK(chip_sel_n, 1'b1)
        op(1'b0, 24'h000005, 16'h0000);
        `CHK(q, expv[5])
        op(1'b1, 24'h000021, 16'h9876);
        op(1'b0, 24'h000021, 16'h0000);
        `CHK(q, expv[33])
        req_protect_n = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK(protect_accel_pin, 1'b0)
        op(1'b1, 24'h000002, 16'h1234);
        op(1'b0, 24'h000002, 16'h0000);
        `CHK(q, expv[2])
        req_accel = 1'b1;
        op(1'b1, 24'h000002, 16'h1234);
        req_accel = 1'b0;
        expv[2] = 16'h1234;
        op(1'b0, 24'h000002, 16'h0000);
        `CHK(q, expv[2])
        `CHK(viol, 1'b0)
        results();
    end
endmodule
